// *** src/pcd_regs.vh ***
// register offsets, encodings and fixed values of the command decoder
`ifndef PCD_REGS_VH
`define PCD_REGS_VH
// ----------------------------------------
// command codes
// ----------------------------------------
`define PCD_CMD_RUN       8'h01
`define PCD_CMD_ENSRC     8'h02
`define PCD_CMD_CLRFLT    8'h03
`define PCD_CMD_WLOCK     8'h10
`define PCD_CMD_STORE     8'h11
`define PCD_CMD_RESTORE   8'h12
`define PCD_CMD_FEATURE   8'h19
`define PCD_CMD_FORMAT    8'h20
`define PCD_CMD_SETPT     8'h21
`define PCD_CMD_MARGHI    8'h25
`define PCD_CMD_MARGLO    8'h26
`define PCD_CMD_SUMBYTE   8'h78
`define PCD_CMD_SUMWORD   8'h79
`define PCD_CMD_VFLT      8'h7a
`define PCD_CMD_IFLT      8'h7b
`define PCD_CMD_COMMSTAT  8'h7e
// ----------------------------------------
// fixed reports and encodings
// ----------------------------------------
`define PCD_FEATURE_VAL   8'hd0
`define PCD_FORMAT_VAL    8'h17
`define PCD_ENSRC_NONE    8'h13
`define PCD_ENSRC_PIN     8'h17
`define PCD_ENSRC_CMD     8'h1b
`define PCD_ENSRC_BOTH    8'h1f
`define PCD_WL_ONLYWL     8'h80
`define PCD_WL_RUN        8'h40
`define PCD_WL_BASIC      8'h20
`define PCD_WL_NONE       8'h00
`define PCD_RUN_MLO_IGN   8'h94
`define PCD_RUN_MLO_ACT   8'h98
`define PCD_RUN_MHI_IGN   8'ha4
`define PCD_RUN_MHI_ACT   8'ha8
// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define PCD_SB_OFF        6
`define PCD_SB_CML        1
`define PCD_SW_PGLOST     11
`define PCD_CML_BADCMD    7
`define PCD_CML_BADDATA   6
`define PCD_RST_RUN       8'h00
`define PCD_RST_ENSRC     8'h1f
`define PCD_RST_WLOCK     8'h00
`define PCD_RST_SETPT     16'h0133
`endif

// *** src/pcd_decoder.v ***
// command decoder and register set behind the power bus slave port
`timescale 1ns/10ps
`default_nettype none
`include "pcd_regs.vh"

// Notes on behaviour
// - run/margin byte at 01h plus enable pin decide output on or off.
// - 00xxxx00 turns off; 1000xx00 turns on at nominal setpoint.
// - 94h or 98h selects low margin; 98h acts on margin faults.
// - a4h or a8h selects high margin; a8h acts on margin faults.
// - 13h ignores both sources; 17h follows only the enable pin.
// - 1bh follows only the run byte; 1fh needs both to run.
// - fault-clear zeroes fault status whose cause is gone; alert drops if none remain.
// - fault-clear keeps the unit-off and power-good-lost live bits.
// - lock 80h allows only lock writes; 40h also the run byte.
// - lock 20h adds enable config and setpoint; 00h allows all.
// - the lock register itself is always writable.
// - store-all copies enable config, lock and setpoint into the default store.
// - restore-all reloads enable config, lock and setpoint from the default store.
// - feature report reads fixed d0h.
// - output format reads fixed 17h and is not writable.
// - setpoint is a 16-bit word of 1.9531 mV steps.
// - separate high and low margin words pick the regulated target.
// - fault summary as a byte at 78h and word at 79h.
// - voltage faults at 7ah, current faults at 7bh, one byte each.
// - only listed codes are served; host relies on nothing else.
// - an unknown command sets the invalid-command flag.
// - status bit 6 means unit off; high bit 3 power good lost.
module pcd_decoder (
  input  wire        core_clk,     // logic clock, 10 MHz
  input  wire        sys_rst,      // async reset, active high
  input  wire        clkEn,        // freezes all state when low
  input  wire        cmdValid,     // one-cycle command strobe
  input  wire        cmdWrite,     // 1 write/send, 0 read
  input  wire [7:0]  cmdCode,      // command code
  input  wire [15:0] cmdData,      // write data, byte in low bits
  input  wire        enablePin,    // enable pin, asynchronous
  input  wire        vOvFault,     // fault events, asynchronous levels
  input  wire        vOvWarn,      // overvoltage warning
  input  wire        vUvWarn,      // undervoltage warning
  input  wire        vUvFault,     // undervoltage fault
  input  wire        iOcFault,     // overcurrent fault
  input  wire        iOcUvFault,   // overcurrent with undervoltage
  input  wire        iNegFault,    // negative overcurrent
  input  wire        ddUvFault,    // bias undervoltage
  input  wire        tempFault,    // overtemperature
  input  wire        powerGoodIn,  // power good from the loop, async
  output reg  [15:0] rdData_r,     // read answer
  output reg         rdValid_r,    // one-cycle answer strobe
  output reg         outputOn_r,   // converter switched on
  output reg  [15:0] targetVout_r, // setpoint the loop regulates to
  output reg         marginActOn_r,// margin faults acted upon
  output reg         alert_r       // alert output, active high
);

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  localparam NSYNC = 11;
  reg [NSYNC-1:0] s1_r;
  reg [NSYNC-1:0] s2_r;
  reg [NSYNC-1:0] s3_r;
  reg [NSYNC-1:0] live_r;
  wire [NSYNC-1:0] rawIn;
  assign rawIn = {powerGoodIn, enablePin, tempFault, ddUvFault, iNegFault,
                  iOcUvFault, iOcFault, vUvFault, vUvWarn, vOvWarn,
                  vOvFault};

  // three stages; the filtered level moves when stages two and three agree
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_r   <= {NSYNC{1'b0}};
      s2_r   <= {NSYNC{1'b0}};
      s3_r   <= {NSYNC{1'b0}};
      live_r <= {NSYNC{1'b0}};
    end else if (clkEn) begin
      s1_r   <= rawIn;
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      live_r <= (s2_r & s3_r) | (live_r & (s2_r | s3_r));
    end
  end

  wire pinEn  = live_r[9];
  wire pgLive = live_r[10];

  // ----------------------------------------
  // operating and default registers
  // ----------------------------------------
  reg [7:0]  runCtl_r;
  reg [7:0]  enSrc_r;
  reg [7:0]  wLock_r;
  reg [15:0] setpt_r;
  reg [15:0] margHi_r;
  reg [15:0] margLo_r;
  reg [7:0]  dfEnSrc_r;
  reg [7:0]  dfWLock_r;
  reg [15:0] dfSetpt_r;
  reg [7:0]  vFlt_r;
  reg [7:0]  iFlt_r;
  reg [2:0]  miscFlt_r;   // bias uv, temp, other
  reg [7:0]  cml_r;

  // write permission by lock level
  function wrAllowed;
    input [7:0] lock;
    input [7:0] code;
    begin
      case (lock)
        `PCD_WL_ONLYWL: wrAllowed = (code == `PCD_CMD_WLOCK);
        `PCD_WL_RUN:    wrAllowed = (code == `PCD_CMD_WLOCK) ||
                                    (code == `PCD_CMD_RUN);
        // basic level, anything else opens all
        `PCD_WL_BASIC:  wrAllowed = (code == `PCD_CMD_WLOCK) ||
                                    (code == `PCD_CMD_RUN) ||
                                    (code == `PCD_CMD_ENSRC) ||
                                    (code == `PCD_CMD_SETPT);
        default:        wrAllowed = 1'b1;
      endcase
    end
  endfunction

  // writable or send-byte code
  function isWrCode;
    input [7:0] code;
    begin
      case (code)
        `PCD_CMD_RUN, `PCD_CMD_ENSRC, `PCD_CMD_CLRFLT, `PCD_CMD_WLOCK,
        `PCD_CMD_STORE, `PCD_CMD_RESTORE, `PCD_CMD_SETPT,
        `PCD_CMD_MARGHI, `PCD_CMD_MARGLO: isWrCode = 1'b1;
        default: isWrCode = 1'b0;
      endcase
    end
  endfunction

  // readable code
  function isRdCode;
    input [7:0] code;
    begin
      case (code)
        `PCD_CMD_RUN, `PCD_CMD_ENSRC, `PCD_CMD_WLOCK, `PCD_CMD_FEATURE,
        `PCD_CMD_FORMAT, `PCD_CMD_SETPT, `PCD_CMD_MARGHI,
        `PCD_CMD_MARGLO, `PCD_CMD_SUMBYTE, `PCD_CMD_SUMWORD,
        `PCD_CMD_VFLT, `PCD_CMD_IFLT, `PCD_CMD_COMMSTAT: isRdCode = 1'b1;
        default: isRdCode = 1'b0;
      endcase
    end
  endfunction

  wire doWr     = clkEn & cmdValid & cmdWrite;
  wire doRd     = clkEn & cmdValid & ~cmdWrite;
  // lock register stays writable at every level
  wire permit   = wrAllowed(wLock_r, cmdCode);
  wire badCmd   = cmdValid & (cmdWrite ? ~isWrCode(cmdCode)
                                       : ~isRdCode(cmdCode));
  wire blocked  = doWr & isWrCode(cmdCode) & ~permit;
  wire wrOk     = doWr & isWrCode(cmdCode) & permit;
  wire clrFault = wrOk & (cmdCode == `PCD_CMD_CLRFLT);

  // ----------------------------------------
  // register writes, store and restore
  // ----------------------------------------
  // margin words keep no default copy, only the nvm-backed ones do
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      runCtl_r  <= `PCD_RST_RUN;
      enSrc_r   <= `PCD_RST_ENSRC;
      wLock_r   <= `PCD_RST_WLOCK;
      setpt_r   <= `PCD_RST_SETPT;
      margHi_r  <= `PCD_RST_SETPT;
      margLo_r  <= `PCD_RST_SETPT;
      dfEnSrc_r <= `PCD_RST_ENSRC;
      dfWLock_r <= `PCD_RST_WLOCK;
      dfSetpt_r <= `PCD_RST_SETPT;
    end else if (wrOk) begin
      case (cmdCode)
        `PCD_CMD_RUN:    runCtl_r <= cmdData[7:0];
        `PCD_CMD_ENSRC:  enSrc_r  <= cmdData[7:0];
        `PCD_CMD_WLOCK:  wLock_r  <= cmdData[7:0];
        `PCD_CMD_SETPT:  setpt_r  <= cmdData;
        `PCD_CMD_MARGHI: margHi_r <= cmdData;
        `PCD_CMD_MARGLO: margLo_r <= cmdData;
        `PCD_CMD_STORE: begin
          dfEnSrc_r <= enSrc_r;
          dfWLock_r <= wLock_r;
          dfSetpt_r <= setpt_r;
        end
        `PCD_CMD_RESTORE: begin
          enSrc_r <= dfEnSrc_r;
          wLock_r <= dfWLock_r;
          setpt_r <= dfSetpt_r;
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // on/off and target selection
  // ----------------------------------------
  reg runReq;
  reg wantOn;
  reg [15:0] tgt;
  reg actFlt;
  always @* begin
    runReq = runCtl_r[7] & ~runCtl_r[6] & ~runCtl_r[1] & ~runCtl_r[0];
    tgt    = setpt_r;
    actFlt = 1'b0;
    case (runCtl_r)
      `PCD_RUN_MLO_IGN: tgt = margLo_r;
      `PCD_RUN_MLO_ACT: begin
        tgt    = margLo_r;
        actFlt = 1'b1;
      end
      `PCD_RUN_MHI_IGN: tgt = margHi_r;
      `PCD_RUN_MHI_ACT: begin
        tgt    = margHi_r;
        actFlt = 1'b1;
      end
      default: runReq = runReq & (runCtl_r[5:4] == 2'b00);
    endcase
    case (enSrc_r)
      `PCD_ENSRC_NONE: wantOn = 1'b0;
      `PCD_ENSRC_PIN:  wantOn = pinEn;
      `PCD_ENSRC_CMD:  wantOn = runReq;
      default:         wantOn = runReq & pinEn;
    endcase
  end

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      outputOn_r    <= 1'b0;
      targetVout_r  <= `PCD_RST_SETPT;
      marginActOn_r <= 1'b0;
    end else if (clkEn) begin
      outputOn_r    <= wantOn;
      targetVout_r  <= tgt;
      marginActOn_r <= actFlt;
    end
  end

  // ----------------------------------------
  // sticky fault status
  // ----------------------------------------
  // a fault present during the clear survives: set wins over clear
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      vFlt_r    <= 8'h00;
      iFlt_r    <= 8'h00;
      miscFlt_r <= 3'b000;
      cml_r     <= 8'h00;
      alert_r   <= 1'b0;
    end else if (clkEn) begin
      vFlt_r    <= (clrFault ? 8'h00 : vFlt_r) |
                   {live_r[0], live_r[1], live_r[2], live_r[3], 4'h0};
      iFlt_r    <= (clrFault ? 8'h00 : iFlt_r) |
                   {live_r[4], live_r[5], 1'b0, live_r[6], 4'h0};
      miscFlt_r <= (clrFault ? 3'b000 : miscFlt_r) |
                   {live_r[7], live_r[8], 1'b0};
      cml_r     <= (clrFault ? 8'h00 : cml_r) |
                   {clkEn & badCmd, blocked, 6'h00};
      alert_r   <= (alert_r & ~clrFault) | (|live_r[8:0]) |
                   (clkEn & badCmd) | blocked;
    end
  end

  // ----------------------------------------
  // status assembly and read answer
  // ----------------------------------------
  reg [15:0] sumWord;
  always @* begin
    sumWord = 16'h0000;
    // unit off and power good lost
    sumWord[`PCD_SB_OFF]    = ~outputOn_r;
    sumWord[`PCD_SW_PGLOST] = ~pgLive;
    sumWord[5]  = vFlt_r[7];
    sumWord[4]  = iFlt_r[7];
    sumWord[3]  = miscFlt_r[2];
    sumWord[2]  = miscFlt_r[1];
    sumWord[`PCD_SB_CML] = |cml_r;
    sumWord[15] = |vFlt_r;
    sumWord[14] = |iFlt_r;
    sumWord[13] = miscFlt_r[2];
  end

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdData_r  <= 16'h0000;
      rdValid_r <= 1'b0;
    end else if (clkEn) begin
      rdValid_r <= doRd;
      if (doRd) begin
        case (cmdCode)
          `PCD_CMD_RUN:      rdData_r <= {8'h00, runCtl_r};
          `PCD_CMD_ENSRC:    rdData_r <= {8'h00, enSrc_r};
          `PCD_CMD_WLOCK:    rdData_r <= {8'h00, wLock_r};
          `PCD_CMD_FEATURE:  rdData_r <= {8'h00, `PCD_FEATURE_VAL};
          `PCD_CMD_FORMAT:   rdData_r <= {8'h00, `PCD_FORMAT_VAL};
          `PCD_CMD_SETPT:    rdData_r <= setpt_r;
          `PCD_CMD_MARGHI:   rdData_r <= margHi_r;
          `PCD_CMD_MARGLO:   rdData_r <= margLo_r;
          `PCD_CMD_SUMBYTE:  rdData_r <= {8'h00, sumWord[7:0]};
          `PCD_CMD_SUMWORD:  rdData_r <= sumWord;
          `PCD_CMD_VFLT:     rdData_r <= {8'h00, vFlt_r};
          `PCD_CMD_IFLT:     rdData_r <= {8'h00, iFlt_r};
          `PCD_CMD_COMMSTAT: rdData_r <= {8'h00, cml_r};
          default:           rdData_r <= 16'h0000;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// *** testbench/pcd_host_model.sv ***
// host controller model offering deframed commands
`timescale 1ns/10ps
`default_nettype none
module pcd_host_model (
  input  wire logic        core_clk,  // logic clock
  output var  logic        cmdValid,  // command strobe
  output var  logic        cmdWrite,  // 1 write, 0 read
  output var  logic [7:0]  cmdCode,   // command code
  output var  logic [15:0] cmdData,   // write data
  input  wire logic [15:0] rdData_r,  // read answer
  input  wire logic        rdValid_r  // answer strobe
);
  logic slow; // idle gap before each command when set

  initial begin
    slow = 1'b0;
    cmdValid = 1'b0;
    cmdWrite = 1'b0;
    cmdCode = 8'h00;
    cmdData = 16'h0000;
  end

  task automatic xfer(input logic w, input logic [7:0] c,
                      input logic [15:0] d, output logic [15:0] q,
                      output logic ok);
    if (slow)
      repeat (3) @(negedge core_clk);
    @(negedge core_clk);
    cmdValid = 1'b1;
    cmdWrite = w;
    cmdCode = c;
    cmdData = (c == 8'h03 || c == 8'h11 || c == 8'h12) ? 16'h0000 : d;
    @(negedge core_clk);
    cmdValid = 1'b0;
    cmdData = ~cmdData; // released data no longer valid
    q = rdData_r;
    ok = w || rdValid_r === 1'b1;
  endtask
endmodule
`default_nettype wire

// *** testbench/pcd_dec_checker.sv ***
// port assertions for the command decoder
`timescale 1ns/10ps
`default_nettype none
module pcd_dec_checker (
  input wire logic        core_clk,      // logic clock
  input wire logic        sys_rst,       // async reset
  input wire logic        clkEn,         // clock enable
  input wire logic        cmdValid,      // command strobe
  input wire logic        cmdWrite,      // write flag
  input wire logic [7:0]  cmdCode,       // command code
  input wire logic [15:0] rdData_r,      // read answer
  input wire logic        rdValid_r,     // answer strobe
  input wire logic [15:0] targetVout_r,  // regulated target
  input wire logic        marginActOn_r, // margin faults acted on
  input wire logic        alert_r        // alert level
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic rdReq;
  logic clrReq;
  // taken read and taken fault-clear
  assign rdReq = cmdValid && clkEn && !cmdWrite;
  assign clrReq = cmdValid && clkEn && cmdWrite && cmdCode == 8'h03;

  a_read_answer: assert property (rdReq |=> rdValid_r)
    else $error("read not answered");
  a_no_stray_answer: assert property (
    clkEn && !rdReq |=> !rdValid_r)
    else $error("answer without read");
  a_feature_fixed: assert property (
    rdReq && cmdCode == 8'h19 |=> rdData_r == 16'h00d0)
    else $error("feature report wrong");
  a_format_fixed: assert property (
    rdReq && cmdCode == 8'h20 |=> rdData_r == 16'h0017)
    else $error("format report wrong");
  a_unknown_zero: assert property (
    rdReq && cmdCode == 8'h55 |=> rdData_r == 16'h0000)
    else $error("unknown read not zero");
  a_unknown_alert: assert property (
    rdReq && cmdCode == 8'h55 |-> ##[1:2] alert_r)
    else $error("unknown code raised no alert");
  a_alert_clear_only: assert property (
    $fell(alert_r) |-> $past(clrReq) || $past(clrReq, 2))
    else $error("alert fell without clear");
  a_read_keeps: assert property (rdReq |=> $stable(targetVout_r))
    else $error("read changed target");

  c_word_read: cover property (rdReq && cmdCode == 8'h79);
  c_alert_drop: cover property ($fell(alert_r));
  c_margin_act: cover property ($rose(marginActOn_r));
endmodule

bind pcd_decoder pcd_dec_checker u_pcd_dec_checker (.core_clk, .sys_rst,
  .clkEn, .cmdValid, .cmdWrite, .cmdCode, .rdData_r, .rdValid_r,
  .targetVout_r, .marginActOn_r, .alert_r);
`default_nettype wire

// *** testbench/tb_top.sv ***
// self-checking bench for the command decoder
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        clkEn = 1'b1;
  logic        enablePin = 1'b0;
  logic        powerGoodIn = 1'b1;
  logic [8:0]  flt = 9'h000; // fault inputs
  logic        cmdValid;
  logic        cmdWrite;
  logic [7:0]  cmdCode;
  logic [15:0] cmdData;
  logic [15:0] rdData_r;
  logic        rdValid_r;
  logic        outputOn_r;
  logic [15:0] targetVout_r;
  logic        marginActOn_r;
  logic        alert_r;
  int          num_errors = 0;
  int          num_checks = 0;
  int          cycles = 0;
  logic [7:0]  cfg [4] = '{8'h13, 8'h17, 8'h1b, 8'h1f};
  logic [7:0]  rc [6] = '{8'h01, 8'h02, 8'h10, 8'h21, 8'h19, 8'h20};
  logic [15:0] rv [6] = '{16'h0000, 16'h001f, 16'h0000, 16'h0133,
                          16'h00d0, 16'h0017};
  logic [7:0]  rp [7] = '{8'h80, 8'h8c, 8'h94, 8'h98, 8'ha4, 8'ha8, 8'h3c};
  logic [17:0] rx [7] = '{18'h20180, 18'h20180, 18'h20100, 18'h30100,
                          18'h20200, 18'h30200, 18'h00000};
  logic [32:0] lt [8] = '{{8'h80, 8'h01, 16'h0080, 1'b0},
    {8'h80, 8'h02, 16'h0017, 1'b0}, {8'h40, 8'h01, 16'h0000, 1'b1},
    {8'h40, 8'h02, 16'h0017, 1'b0}, {8'h20, 8'h02, 16'h001f, 1'b1},
    {8'h20, 8'h21, 16'h0150, 1'b1}, {8'h20, 8'h25, 16'h0250, 1'b0},
    {8'h00, 8'h25, 16'h0250, 1'b1}};

  always #50 core_clk = ~core_clk;

  pcd_decoder u_pcd_decoder (.core_clk, .sys_rst, .clkEn, .cmdValid,
    .cmdWrite, .cmdCode, .cmdData, .enablePin, .vOvFault(flt[0]),
    .vOvWarn(flt[1]), .vUvWarn(flt[2]), .vUvFault(flt[3]),
    .iOcFault(flt[4]), .iOcUvFault(flt[5]), .iNegFault(flt[6]),
    .ddUvFault(flt[7]), .tempFault(flt[8]), .powerGoodIn, .rdData_r,
    .rdValid_r, .outputOn_r, .targetVout_r, .marginActOn_r, .alert_r);

  pcd_host_model u_pcd_host_model (.core_clk, .cmdValid, .cmdWrite,
    .cmdCode, .cmdData, .rdData_r, .rdValid_r);

  task automatic wrap_up();
    if (num_errors == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // hang guard, far above the expected run length
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      wrap_up();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    logic [15:0] q;
    logic        ok;
    u_pcd_host_model.xfer(1'b1, c, d, q, ok);
  endtask

  task automatic rd(input logic [7:0] c, input logic [15:0] e,
                    input logic [15:0] m);
    logic [15:0] q;
    logic        ok;
    u_pcd_host_model.xfer(1'b0, c, 16'h0000, q, ok);
    chk({15'h0, ok}, 16'h0001);
    chk(q & m, e);
  endtask

  // refused writes keep the old value and flag bad data
  task automatic tryw(input logic [7:0] c, input logic [15:0] d,
                      input logic a);
    logic [15:0] q;
    logic        ok;
    u_pcd_host_model.xfer(1'b0, c, 16'h0000, q, ok);
    wr(c, d);
    rd(c, a ? d : q, 16'hffff);
    if (!a)
      rd(8'h7e, 16'h0040, 16'h0040);
  endtask

  initial begin
    logic ok;
    repeat (20) @(negedge core_clk);
    sys_rst = 1'b0;
    for (int i = 0; i < 6; i++) rd(rc[i], rv[i], 16'hffff);
    for (int c = 0; c < 4; c++) begin
      for (int k = 0; k < 4; k++) begin
        wr(8'h02, {8'h00, cfg[c]});
        wr(8'h01, {8'h00, k[1], 7'h00});
        enablePin = k[0];
        repeat (8) @(negedge core_clk);
        ok = (c == 1) ? k[0] : (c == 2) ? k[1] : (c == 3) && k[0] && k[1];
        chk({15'h0, outputOn_r}, {15'h0, ok});
      end
    end
    wr(8'h02, 16'h001b);
    wr(8'h21, 16'h0180);
    wr(8'h25, 16'h0200);
    wr(8'h26, 16'h0100);
    for (int i = 0; i < 7; i++) begin
      wr(8'h01, {8'h00, rp[i]});
      repeat (2) @(negedge core_clk);
      chk({14'h0, outputOn_r, marginActOn_r}, {14'h0, rx[i][17:16]});
      if (rx[i][17]) chk(targetVout_r, rx[i][15:0]);
    end
    for (int i = 0; i < 8; i++) begin
      wr(8'h10, {8'h00, lt[i][32:25]});
      rd(8'h10, {8'h00, lt[i][32:25]}, 16'hffff);
      tryw(lt[i][24:17], lt[i][16:1], lt[i][0]);
    end
    flt = 9'h011;
    repeat (8) @(negedge core_clk);
    rd(8'h7a, 16'h0080, 16'h0080);
    rd(8'h7b, 16'h0080, 16'h0080);
    chk({15'h0, alert_r}, 16'h0001);
    flt = 9'h000;
    repeat (8) @(negedge core_clk);
    wr(8'h03, 16'h0000);
    repeat (4) @(negedge core_clk);
    rd(8'h7a, 16'h0000, 16'hffff);
    rd(8'h78, 16'h0040, 16'hffff);
    chk({15'h0, alert_r}, 16'h0000);
    powerGoodIn = 1'b0;
    repeat (8) @(negedge core_clk);
    wr(8'h03, 16'h0000);
    rd(8'h79, 16'h0840, 16'h0840);
    // a fault still present during the clear must survive it
    flt = 9'h001;
    repeat (8) @(negedge core_clk);
    wr(8'h03, 16'h0000);
    repeat (4) @(negedge core_clk);
    rd(8'h7a, 16'h0080, 16'h0080);
    chk({15'h0, alert_r}, 16'h0001);
    flt = 9'h000;
    u_pcd_host_model.slow = 1'b1;
    wr(8'h21, 16'h01a0);
    wr(8'h11, 16'h0000);
    wr(8'h21, 16'h0150);
    wr(8'h12, 16'h0000);
    rd(8'h21, 16'h01a0, 16'hffff);
    rd(8'h55, 16'h0000, 16'hffff);
    rd(8'h7e, 16'h0080, 16'h0080);
    clkEn = 1'b0;
    repeat (4) @(negedge core_clk);
    clkEn = 1'b1;
    sys_rst = 1'b1;
    repeat (3) @(negedge core_clk);
    sys_rst = 1'b0;
    rd(8'h21, 16'h0133, 16'hffff);
    wrap_up();
  end
endmodule
`default_nettype wire
